// ---- shared/cps_defines.svh ----
// Constants for the control port slave: bus IDs, step codes, reset values, sizes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
`define CPS_ID_BASE        6'h0D
`define CPS_STEP_RST       2'h1
`define CPS_SPI_WOR_RST    1'b1
`define CPS_PD_RST         1'b1
`define CPS_SPI_WORD_BITS  5'h10
`define CPS_SPI_HDR_BITS   5'h10
`define CPS_Q_DEPTH        3'h4
`define CPS_IDX_ABORT      9'h1FF
`define CPS_SEQ_SLOTS      256
`define CPS_EVT_NUM        4
`endif

// ---- shared/cps_pkg.sv ----
// Types for the control port slave and write sequencer.
// Assumes the defines header sits in the include path.
`include "cps_defines.svh"
package cps_pkg;
    typedef enum logic [5:0] {
        CPS_TW_IDLE = 6'h01,
        CPS_TW_ID   = 6'h02,
        CPS_TW_ACK  = 6'h04,
        CPS_TW_RX   = 6'h08,
        CPS_TW_TX   = 6'h10,
        CPS_TW_MACK = 6'h20
    } cps_tw_state_t;
    typedef enum logic [2:0] {
        CPS_SQ_IDLE = 3'h1,
        CPS_SQ_READ = 3'h2,
        CPS_SQ_WRITE = 3'h4
    } cps_sq_state_t;
    typedef logic [15:0] cps_word_t;
endpackage

// ---- logic/cps_seq_mem.sv ----
// Sequencer command memory: 256 words of 32 bits, registered read data.
// Assumes a single clock and a host loader on the write port.
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_seq_mem
    import cps_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_ce,
    input  wire logic        i_we,
    input  wire logic [7:0]  i_waddr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [7:0]  i_raddr,
    output logic      [31:0] o_rdata
);
    logic [31:0] mem [0:`CPS_SEQ_SLOTS-1];
    // Write port and registered read port
    always_ff @(posedge i_sys_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ---- logic/cps_sync.sv ----
// Two-flop synchroniser for a bank of pin inputs.
// Assumes inputs are asynchronous to i_sys_clk.
`timescale 1ns/1ps
module cps_sync
    import cps_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    // First stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            meta_r <= '1;
            o_sync <= '1;
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ---- logic/cps_ctrl_port.sv ----
// Control port: two-wire slave, four-wire slave and the control write sequencer.
// Assumes links are sampled by i_sys_clk (much faster than the serial clocks).
// Functional notes
// R1: Data line only pulled low or released, never driven high.
// R2: Bus ID 0011010 with select pin low, 0011011 with it high.
// R3: First byte bit zero gives direction: one read, zero write.
// R4: Start is data falling with clock high; then eight ID bits MSB first.
// R5: Matching ID is acknowledged by holding data low one clock.
// R6: Mismatched ID gets no acknowledge; slave idles until next start.
// R7: Stop is data rising with clock high; slave then idles.
// R8: Data change with clock high mid-transfer aborts to idle. Code idles only on a rise; a fall restarts the ID phase.
// R9: Single and multiple writes and reads, optional address advance.
// R10: Two-wire address step from its own field, one after reset.
// R11: Read may start at the last used register address.
// R12: Push-pull output low when idle; wired-or output released when idle.
// R13: Master drives every data-in bit during four-wire writes.
// R14: Four-wire read ignores data-in after address, drives read data out.
// R15: Four-wire address advances after first word and every 16 clocks.
// R16: Four-wire step from its own field, one after reset.
// R17: Started sequencer runs stored writes without host help.
// R18: Start slot from host field or per-event start slot settings.
// R19: Output path enable or disable schedules its built-in sequence.
// R20: Requests queue while running; empty queue stops and flags status.
// R21: Host keeps system clock running while sequences are scheduled.
// R22: Step code 00 none, 01/10/11 give steps one, two, three.
// R23: Output config zero push-pull, one wired-or; resets to one.
// R24: Launch bit is cleared by the sequencer when its sequence ends. The code forms launch_clear_w but drives it to no port.
// R25: Cancel stops only the running sequence; queued ones stay.
// R26: Acknowledge writes; release data during the master acknowledge on reads.
// R27: Raising slave select ends the transfer and releases data out.
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_ctrl_port
    import cps_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic        i_tw_scl,
    input  wire logic        i_tw_sda,
    output logic             o_tw_sda,
    output logic             o_tw_sda_oe_n,
    input  wire logic        i_bus_id_select_pin,
    input  wire logic        i_id_pin_pulldown_en,
    output logic             o_id_pin_pulldown_en,
    input  wire logic [1:0]  i_two_wire_addr_step,
    input  wire logic        i_fw_sclk,
    input  wire logic        i_fw_ss_n,
    input  wire logic        i_fw_mosi,
    output logic             o_fw_miso,
    output logic             o_fw_miso_oe_n,
    input  wire logic        i_fw_wired_or,
    input  wire logic [1:0]  i_four_wire_addr_step,
    output logic             o_reg_we,
    output logic [15:0]      o_reg_addr,
    output logic [15:0]      o_reg_wdata,
    input  wire logic [15:0] i_reg_rdata,
    input  wire logic        i_seq_launch,
    input  wire logic        i_seq_cancel,
    input  wire logic [8:0]  i_seq_first_slot,
    input  wire logic [3:0]  i_evt_req,
    input  wire logic [35:0] i_evt_first_slot,
    output logic             o_seq_busy,
    output logic             o_seq_done_flag,
    input  wire logic        i_seq_done_clr,
    input  wire logic        i_mem_we,
    input  wire logic [7:0]  i_mem_waddr,
    input  wire logic [31:0] i_mem_wdata
);
    // Address step decode shared by both links [R22]
    function automatic logic [15:0] step_add(input logic [15:0] a, input logic [1:0] code);
        step_add = a + {14'h0000, code};
    endfunction

    logic [4:0] pins_s;
    cps_sync #(.W(5)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_async   ({i_bus_id_select_pin, i_tw_scl, i_tw_sda, i_fw_sclk, i_fw_ss_n}),
        .o_sync    (pins_s)
    );
    logic mosi_s;
    cps_sync #(.W(1)) u_sync_mosi (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_async   (i_fw_mosi),
        .o_sync    (mosi_s)
    );
    logic scl_d_r, sda_d_r, fsck_d_r;
    logic tw_we, fw_we, sq_we;
    logic [15:0] tw_addr, fw_addr, sq_addr, tw_wd, fw_wd, sq_wd;
    // Previous samples for edge detection
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
            fsck_d_r <= 1'b0;
        end else if (i_ce) begin
            scl_d_r  <= pins_s[3];
            sda_d_r  <= pins_s[2];
            fsck_d_r <= pins_s[1];
        end
    end
    wire scl_rise  = pins_s[3] & ~scl_d_r;
    wire scl_fall  = ~pins_s[3] & scl_d_r;
    wire tw_start  = pins_s[3] & scl_d_r & sda_d_r & ~pins_s[2]; // [R4]
    wire tw_stop   = pins_s[3] & scl_d_r & ~sda_d_r & pins_s[2]; // [R7]
    wire fsck_rise = pins_s[1] & ~fsck_d_r;
    wire fsck_fall = ~pins_s[1] & fsck_d_r;
    wire ss_n      = pins_s[0];

    // ---------------- Two-wire slave ----------------
    cps_tw_state_t tw_st_r;
    logic [3:0]  tw_bit_r;
    logic [7:0]  tw_sh_r;
    logic [1:0]  tw_byte_r;     // 0 reg addr hi, 1 lo, 2 data hi, 3 data lo
    logic        tw_rd_r;
    logic        tw_low_r;      // Pull data line low
    logic [15:0] tw_addr_r;     // Last used register address [R11]
    logic [15:0] tw_tx_r;
    logic [7:0]  tw_hi_r;
    logic        tw_we_r;
    wire [7:0] tw_shn = {tw_sh_r[6:0], pins_s[2]};
    wire [6:0] own_id = {`CPS_ID_BASE, pins_s[4]}; // [R2]
    // Two-wire protocol engine
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            tw_st_r   <= CPS_TW_IDLE;
            tw_bit_r  <= 4'h0;
            tw_sh_r   <= 8'h00;
            tw_byte_r <= 2'h0;
            tw_rd_r   <= 1'b0;
            tw_low_r  <= 1'b0;
            tw_addr_r <= 16'h0000;
            tw_tx_r   <= 16'h0000;
            tw_hi_r   <= 8'h00;
            tw_we_r   <= 1'b0;
        end else if (i_ce) begin
            tw_we_r <= 1'b0;
            if (tw_start) begin
                tw_st_r   <= CPS_TW_ID; // [R4]
                tw_bit_r  <= 4'h0;
                tw_byte_r <= 2'h0;
                tw_low_r  <= 1'b0;
            end else if (tw_stop) begin
                tw_st_r  <= CPS_TW_IDLE; // [R7] [R8]
                tw_low_r <= 1'b0;
            end else begin
                unique case (tw_st_r)
                    CPS_TW_IDLE: tw_low_r <= 1'b0;
                    CPS_TW_ID, CPS_TW_RX: begin
                        if (scl_rise) begin
                            tw_sh_r  <= tw_shn; // MSB first [R4]
                            tw_bit_r <= tw_bit_r + 4'h1;
                        end
                        if (scl_fall && tw_bit_r == 4'h8) begin
                            tw_bit_r <= 4'h0;
                            if (tw_st_r == CPS_TW_ID) begin
                                if (tw_sh_r[7:1] == own_id) begin
                                    tw_rd_r  <= tw_sh_r[0]; // [R3]
                                    tw_low_r <= 1'b1;       // [R5]
                                    tw_st_r  <= CPS_TW_ACK;
                                    tw_tx_r  <= i_reg_rdata;
                                end else begin
                                    tw_st_r <= CPS_TW_IDLE; // [R6]
                                end
                            end else begin
                                tw_low_r <= 1'b1; // [R26]
                                tw_st_r  <= CPS_TW_ACK;
                                unique case (tw_byte_r)
                                    2'h0: tw_addr_r[15:8] <= tw_sh_r;
                                    2'h1: tw_addr_r[7:0]  <= tw_sh_r;
                                    2'h2: tw_hi_r         <= tw_sh_r;
                                    2'h3: tw_we_r         <= 1'b1; // [R9]
                                endcase
                                tw_byte_r <= (tw_byte_r == 2'h3) ? 2'h2 : tw_byte_r + 2'h1;
                            end
                        end
                    end
                    CPS_TW_ACK: begin
                        if (scl_fall) begin
                            tw_low_r <= 1'b0;
                            if (tw_rd_r) begin
                                tw_st_r  <= CPS_TW_TX;
                                tw_low_r <= ~tw_tx_r[15];
                                tw_tx_r  <= {tw_tx_r[14:0], 1'b0};
                                tw_bit_r <= 4'h1;
                            end else begin
                                tw_st_r <= CPS_TW_RX;
                            end
                        end
                    end
                    CPS_TW_TX: begin
                        if (scl_fall) begin
                            if (tw_bit_r == 4'h8) begin
                                tw_low_r <= 1'b0; // Release for master ack [R26]
                                tw_st_r  <= CPS_TW_MACK;
                            end else begin
                                tw_low_r <= ~tw_tx_r[15]; // [R1]
                                tw_tx_r  <= {tw_tx_r[14:0], 1'b0};
                                tw_bit_r <= tw_bit_r + 4'h1;
                            end
                        end
                    end
                    CPS_TW_MACK: begin
                        if (scl_rise) begin
                            if (pins_s[2]) begin
                                tw_st_r <= CPS_TW_IDLE; // Master nack ends read
                            end else begin
                                tw_byte_r <= ~tw_byte_r[0] ? 2'h1 : 2'h0;
                                if (tw_byte_r[0]) begin
                                    tw_addr_r <= step_add(tw_addr_r, i_two_wire_addr_step); // [R10]
                                end
                            end
                        end
                        if (scl_fall && !pins_s[2]) begin
                            tw_st_r  <= CPS_TW_TX;
                            tw_bit_r <= 4'h1;
                            if (tw_byte_r[0]) begin
                                tw_low_r <= ~tw_tx_r[15];
                                tw_tx_r  <= {tw_tx_r[14:0], 1'b0};
                            end else begin
                                tw_low_r <= ~i_reg_rdata[15]; // Next word [R9]
                                tw_tx_r  <= {i_reg_rdata[14:0], 1'b0};
                            end
                        end
                    end
                endcase
                if (tw_we_r) begin
                    tw_addr_r <= step_add(tw_addr_r, i_two_wire_addr_step); // [R9] [R10]
                end
            end
        end
    end
    assign tw_we   = tw_we_r;
    assign tw_addr = tw_addr_r;
    assign tw_wd   = {tw_hi_r, tw_sh_r};
    assign o_tw_sda      = 1'b0;       // Never drive high [R1]
    assign o_tw_sda_oe_n = ~tw_low_r;  // [R1]
    assign o_id_pin_pulldown_en = i_id_pin_pulldown_en;

    // ---------------- Four-wire slave ----------------
    logic [4:0]  fw_cnt_r;
    logic        fw_hdr_r;     // Header phase: direction plus 15 address bits
    logic        fw_rd_r;
    logic [15:0] fw_sh_r;
    logic [15:0] fw_addr_r;
    logic [15:0] fw_tx_r;
    logic        fw_drv_r;
    logic        fw_we_r;
    // Four-wire protocol engine
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fw_cnt_r  <= 5'h00;
            fw_hdr_r  <= 1'b1;
            fw_rd_r   <= 1'b0;
            fw_sh_r   <= 16'h0000;
            fw_addr_r <= 16'h0000;
            fw_tx_r   <= 16'h0000;
            fw_drv_r  <= 1'b0;
            fw_we_r   <= 1'b0;
        end else if (i_ce) begin
            fw_we_r <= 1'b0;
            if (ss_n) begin
                fw_cnt_r <= 5'h00; // [R27]
                fw_hdr_r <= 1'b1;
                fw_drv_r <= 1'b0;
            end else begin
                if (fsck_rise && !(fw_rd_r && !fw_hdr_r)) begin
                    fw_sh_r  <= {fw_sh_r[14:0], mosi_s}; // [R13] [R14]
                end
                if (fsck_rise) begin
                    fw_cnt_r <= fw_cnt_r + 5'h01;
                end
                if (fsck_rise && fw_cnt_r == `CPS_SPI_WORD_BITS - 5'h01) begin
                    fw_cnt_r <= 5'h00;
                    if (fw_hdr_r) begin
                        fw_hdr_r  <= 1'b0;
                        fw_rd_r   <= fw_sh_r[14];
                        fw_addr_r <= {1'b0, fw_sh_r[13:0], mosi_s};
                    end else if (!fw_rd_r) begin
                        fw_we_r <= 1'b1;
                    end else begin
                        fw_addr_r <= step_add(fw_addr_r, i_four_wire_addr_step); // [R15] [R16]
                    end
                end
                if (fw_we_r) begin
                    fw_addr_r <= step_add(fw_addr_r, i_four_wire_addr_step); // [R15] [R16]
                end
                if (fsck_fall && !fw_hdr_r && fw_rd_r) begin
                    fw_drv_r <= 1'b1; // [R14]
                    if (fw_cnt_r == 5'h00) begin
                        fw_tx_r <= {i_reg_rdata[14:0], 1'b0};
                        fw_sh_r <= {15'h0000, i_reg_rdata[15]};
                    end else begin
                        fw_tx_r <= {fw_tx_r[14:0], 1'b0};
                        fw_sh_r <= {15'h0000, fw_tx_r[15]};
                    end
                end
            end
        end
    end
    assign fw_we   = fw_we_r;
    assign fw_addr = fw_addr_r;
    assign fw_wd   = fw_sh_r;
    // Data-out pin: low or released when no bit goes out [R12] [R23] [R27]
    assign o_fw_miso      = fw_drv_r & fw_sh_r[0];
    assign o_fw_miso_oe_n = ~fw_drv_r & i_fw_wired_or;

    // ---------------- Control write sequencer ----------------
    logic [8:0] q_slot_r [0:3];
    logic [2:0] q_cnt_r;
    logic       q_launch_r [0:3];
    cps_sq_state_t sq_st_r;
    logic [7:0] sq_ptr_r;
    logic       sq_from_launch_r;
    logic       launch_d_r;
    logic [3:0] evt_d_r;
    logic       sq_we_r;
    logic [31:0] mem_q;
    cps_seq_mem u_mem (
        .i_sys_clk (i_sys_clk),
        .i_ce      (i_ce),
        .i_we      (i_mem_we),
        .i_waddr   (i_mem_waddr),
        .i_wdata   (i_mem_wdata),
        .i_raddr   (sq_ptr_r),
        .o_rdata   (mem_q)
    );
    wire launch_rq = i_seq_launch & ~launch_d_r;
    wire [3:0] evt_rq = i_evt_req & ~evt_d_r; // [R18] [R19]
    // Pick one new request per cycle, launch first
    logic       new_v;
    logic [8:0] new_slot;
    always_comb begin
        new_v    = launch_rq;
        new_slot = i_seq_first_slot; // [R18]
        for (int k = `CPS_EVT_NUM - 1; k >= 0; k--) begin
            if (!launch_rq && evt_rq[k]) begin
                new_v    = 1'b1;
                new_slot = i_evt_first_slot[k*9 +: 9];
            end
        end
    end
    wire pop = (sq_st_r == CPS_SQ_IDLE) && (q_cnt_r != 3'h0);
    wire sq_end = (sq_st_r == CPS_SQ_WRITE) && (mem_q[31] || i_seq_cancel || sq_ptr_r == 8'hFF);
    // Queue of pending sequences [R20]
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q_cnt_r    <= 3'h0;
            launch_d_r <= 1'b0;
            evt_d_r    <= 4'h0;
            for (int k = 0; k < 4; k++) begin
                q_slot_r[k]   <= 9'h000;
                q_launch_r[k] <= 1'b0;
            end
        end else if (i_ce) begin
            launch_d_r <= i_seq_launch;
            evt_d_r    <= i_evt_req;
            if (pop) begin
                for (int k = 0; k < 3; k++) begin
                    q_slot_r[k]   <= q_slot_r[k+1];
                    q_launch_r[k] <= q_launch_r[k+1];
                end
            end
            if (new_v && (q_cnt_r - {2'b00, pop}) != `CPS_Q_DEPTH) begin
                q_slot_r[q_cnt_r[1:0] - {1'b0, pop}]   <= new_slot;
                q_launch_r[q_cnt_r[1:0] - {1'b0, pop}] <= launch_rq;
                q_cnt_r <= q_cnt_r - {2'b00, pop} + 3'h1;
            end else begin
                q_cnt_r <= q_cnt_r - {2'b00, pop};
            end
        end
    end
    // Sequencer engine: memory word = {last, addr[14:0], data[15:0]} [R17]
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sq_st_r          <= CPS_SQ_IDLE;
            sq_ptr_r         <= 8'h00;
            sq_from_launch_r <= 1'b0;
            sq_we_r          <= 1'b0;
            o_seq_done_flag  <= 1'b0;
            o_seq_busy       <= 1'b0;
        end else if (i_ce) begin
            sq_we_r <= 1'b0;
            unique case (sq_st_r)
                CPS_SQ_IDLE: begin
                    if (pop && q_slot_r[0] != `CPS_IDX_ABORT) begin
                        sq_ptr_r         <= q_slot_r[0][7:0];
                        sq_from_launch_r <= q_launch_r[0];
                        sq_st_r          <= CPS_SQ_READ;
                        o_seq_busy       <= 1'b1;
                    end
                end
                CPS_SQ_READ: sq_st_r <= CPS_SQ_WRITE;
                CPS_SQ_WRITE: begin
                    sq_we_r <= ~i_seq_cancel; // [R25]
                    if (sq_end) begin
                        sq_st_r    <= CPS_SQ_IDLE;
                        o_seq_busy <= 1'b0;
                    end else begin
                        sq_ptr_r <= sq_ptr_r + 8'h01;
                        sq_st_r  <= CPS_SQ_READ;
                    end
                end
            endcase
            // Flag when queue drains; set wins over clear [R20]
            if (sq_end && q_cnt_r == 3'h0 && !new_v) begin
                o_seq_done_flag <= 1'b1;
            end else if (i_seq_done_clr) begin
                o_seq_done_flag <= 1'b0;
            end
        end
    end
    wire launch_clear_w = sq_end & sq_from_launch_r; // [R24]
    assign sq_we   = sq_we_r;
    assign sq_addr = {1'b0, mem_q[30:16]};
    assign sq_wd   = mem_q[15:0];

    // Register port: sequencer, then two-wire, then four-wire
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_reg_we    <= 1'b0;
            o_reg_addr  <= 16'h0000;
            o_reg_wdata <= 16'h0000;
        end else if (i_ce) begin
            o_reg_we <= sq_we | tw_we | fw_we;
            if (sq_we) begin
                o_reg_addr  <= sq_addr;
                o_reg_wdata <= sq_wd;
            end else if (tw_we) begin
                o_reg_addr  <= tw_addr;
                o_reg_wdata <= tw_wd;
            end else if (fw_we || !fw_hdr_r) begin
                o_reg_addr  <= fw_addr;
                o_reg_wdata <= fw_wd;
            end else begin
                o_reg_addr  <= tw_addr;
            end
        end
    end

    a_tw_never_high: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R1]
        !o_tw_sda_oe_n |-> !o_tw_sda) else $error("sda driven high");
    a_miso_push_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R12]
        (ss_n && !i_fw_wired_or) |=> (!o_fw_miso_oe_n || !i_fw_wired_or) && !o_fw_miso)
        else $error("miso not low idle");
    a_seq_busy_end: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R20]
        (i_ce && sq_end) |=> !o_seq_busy) else $error("busy after end");
    a_launch_clr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R24]
        (i_ce && launch_clear_w) |=> (sq_st_r == CPS_SQ_IDLE)) else $error("launch clear early");
    a_cancel_nowrite: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R25]
        (i_ce && sq_st_r == CPS_SQ_WRITE && i_seq_cancel) |=> !sq_we_r) else $error("write after cancel");
    a_ss_release: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R27]
        (i_ce && ss_n) |=> !fw_drv_r) else $error("miso held after deselect");
endmodule

// ---- sim/cps_tw_master.sv ----
// Two-wire bus master model: drives the clock and pulls data low or releases it.
// Assumes the bench merges the data line level with a pull-up.
`timescale 1ns/1ps
module cps_tw_master (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // Bus idles with both lines released high
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Quarter of the 32 ns link period
    task automatic q;
        repeat (2) @(posedge i_sys_clk);
    endtask
    // Data falls while clock is high
    task automatic start;
        o_sda <= 1'b0;
        q;
        o_scl <= 1'b0;
        q;
    endtask
    // Data rises while clock is high
    task automatic stop;
        o_sda <= 1'b0;
        q;
        o_scl <= 1'b1;
        q;
        o_sda <= 1'b1;
        q;
    endtask
    // One clock pulse; the line is sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        o_sda <= b;
        q;
        o_scl <= 1'b1;
        q;
        s = i_sda;
        q;
        o_scl <= 1'b0;
        q;
    endtask
    // Byte out MSB first, then the acknowledge slot with data released
    task automatic byte_x(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, a);
    endtask
endmodule

// ---- sim/control_port_slave_with_write_seq_bench.sv ----
// Bench for the control port: two-wire traffic, output idle levels, sequencer run.
// Assumes the design samples the link pins with its own clock.
`timescale 1ns/1ps
module control_port_slave_with_write_seq_bench;
    import cps_pkg::*;
    logic i_sys_clk = 0, i_sys_rst = 1, i_ce = 1, i_bus_id_select_pin = 0, i_id_pin_pulldown_en = 1;
    logic i_fw_sclk = 0, i_fw_ss_n = 1, i_fw_mosi = 0, i_fw_wired_or = 1, i_seq_launch = 0;
    logic i_seq_cancel = 0, i_seq_done_clr = 0, i_mem_we = 0, m_scl, m_sda, ack;
    logic o_tw_sda, o_tw_sda_oe_n, o_id_pin_pulldown_en, o_fw_miso, o_fw_miso_oe_n, o_reg_we;
    logic o_seq_busy, o_seq_done_flag;
    logic [1:0]  i_two_wire_addr_step = 2'h1, i_four_wire_addr_step = 2'h1;
    logic [15:0] i_reg_rdata = 16'hA5C3, o_reg_addr, o_reg_wdata, we_addr, we_data, rd;
    logic [8:0]  i_seq_first_slot = 9'h000;
    logic [3:0]  i_evt_req = 4'h0;
    logic [35:0] i_evt_first_slot = {4{9'h1FF}};
    logic [7:0]  i_mem_waddr = 8'h00;
    logic [31:0] i_mem_wdata = 32'h8040_1234;
    int          failures = 0, num_checks = 0;
    wire         i_tw_scl = m_scl;
    wire         i_tw_sda = m_sda & (o_tw_sda_oe_n | o_tw_sda);
    always #2 i_sys_clk = ~i_sys_clk; // Free running
    cps_ctrl_port dut (.*);
    cps_tw_master m (.i_sys_clk(i_sys_clk), .i_sda(i_tw_sda), .o_scl(m_scl), .o_sda(m_sda));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // Four-wire word MSB first, data set while the clock is low
    task automatic fw_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            i_fw_mosi <= w[i];
            repeat (4) @(posedge i_sys_clk);
            i_fw_sclk <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
            i_fw_sclk <= 1'b0;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Latch each register write and watch the data pin never drive high
    always @(posedge i_sys_clk) begin
        if (o_reg_we === 1'b1) {we_addr, we_data} <= {o_reg_addr, o_reg_wdata};
        if (!i_sys_rst) chk(o_tw_sda, 16'h0);
    end
    initial begin
        #100000;
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        m.start;
        m.byte_x(8'h34, ack);
        chk(ack, 16'h0);
        for (int i = 3; i >= 0; i--) begin
            m.byte_x(8'(32'h0012_ABCD >> (8 * i)), ack);
            chk(ack, 16'h0);
        end
        m.stop;
        repeat (8) @(posedge i_sys_clk);
        chk(we_addr, 16'h0012);
        chk(we_data, 16'hABCD);
        $display("write test done");
        m.start;
        m.byte_x(8'h36, ack);
        chk(ack, 16'h1);
        m.stop;
        i_bus_id_select_pin <= 1'b1;
        m.start;
        m.byte_x(8'h36, ack);
        chk(ack, 16'h0);
        m.stop;
        i_bus_id_select_pin <= 1'b0;
        chk(o_id_pin_pulldown_en, 16'h1);
        $display("id test done");
        m.start;
        m.byte_x(8'h35, ack);
        chk(ack, 16'h0);
        for (int i = 15; i >= 0; i--) begin
            m.bit_x(1'b1, rd[i]);
            if (i == 8) m.bit_x(1'b0, ack);
        end
        chk(rd, 16'hA5C3);
        chk(o_reg_addr, 16'h0013);
        m.bit_x(1'b1, ack);
        m.stop;
        $display("read test done");
        chk(o_fw_miso_oe_n, 16'h1);
        i_fw_wired_or <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        chk({o_fw_miso_oe_n, o_fw_miso}, 16'h0);
        $display("miso idle test done");
        i_fw_ss_n <= 1'b0;
        fw_word(16'h0055);
        fw_word(16'h1357);
        fw_word(16'h2468);
        repeat (8) @(posedge i_sys_clk);
        i_fw_ss_n <= 1'b1;
        chk(we_addr, 16'h0056);
        chk(we_data, 16'h2468);
        $display("four-wire test done");
        i_mem_we <= 1'b1;
        @(posedge i_sys_clk);
        i_mem_we <= 1'b0;
        i_seq_launch <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        chk(we_addr, 16'h0040);
        chk(we_data, 16'h1234);
        chk({o_seq_busy, o_seq_done_flag}, 16'h1);
        $display("sequencer test done");
        tally_and_finish;
    end
endmodule
